// ===== logic/dpc_pkg.sv
// package for the datapath configuration register block
// assumes one clock domain; all figures below are register layout and reset values
package dpc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] DATAPATH_CONTROL_ADDR  = 8'h22;
  localparam logic [7:0] DATAPATH_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FWD_LOAD_INHIBIT_BIT      = 7;
  localparam int PIXEL_PASS_UNGATED_BIT    = 6;
  localparam int VALID_STROBE_POLARITY_BIT = 5;
  localparam int AUDIO_REPEATER_REGEN_BIT  = 4;
  localparam int QUAD_OVERRIDE_BIT         = 3;
  localparam int COLOR_18BIT_BIT           = 2;
  localparam int AUDIO_INBAND_BIT          = 1;
  localparam int QUAD_ENABLE_BIT           = 0;
  localparam int FWD_FIELD_WIDTH           = 7;

  // ****************************************
  // synchroniser reset value
  // ****************************************
  localparam logic SYNC_RESET_LEVEL = 1'b0;

  // ****************************************
  // decoded control reset levels
  // ****************************************
  // protection, audio and audio on the pixel pins start out allowed, every other control starts off
  localparam logic ALLOW_RESET_LEVEL = 1'b1;
  localparam logic FLAG_RESET_LEVEL  = 1'b0;

endpackage

// ===== logic/dpc_sync2.sv
// two-flop synchroniser for one asynchronous level
// assumes the input comes from a pin outside the CLK domain
`timescale 1ns/100ps

module dpc_sync2 (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } dpc_sync_state_type;

  dpc_sync_state_type state;
  dpc_sync_state_type next_state;

  // the first stage feeds only the second stage
  always_comb begin
    next_state.meta   = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= '{meta: dpc_pkg::SYNC_RESET_LEVEL, stable: dpc_pkg::SYNC_RESET_LEVEL};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule // dpc_sync2

// ===== logic/dpc_datapath_config.sv
// What this block does
// - With the load inhibit bit 7 set, loads from the forward channel are ignored.
// - With the load inhibit bit clear, forward-channel loads update the register.
// - Bits 6..0 are refreshed from remote serializer settings unless bit 7 is set.
// - Bit 6 set forwards pixel data regardless of the valid strobe, else the strobe frames.
// - While bit 6 is in effect, content protection and packetized audio are disabled.
// - Bit 6 has no effect when the serializer lacks content protection support.
// - Bit 5 picks strobe polarity: 1 active low, 0 active high.
// - Bit 4 set keeps packetized audio off the pixel pins, clear puts it there unless bit 6 is in effect.
// - Bit 3 set takes quad-channel enable from bit 0, clear disables quad audio.
// - Bit 2 set selects 18-bit video, clear selects 24-bit video.
// - Bit 1 set selects in-band audio transport, clear selects data-island transport.
// - Bit 0 enables quad-channel audio when set, provided bit 3 is also set.
//
// holds the datapath control register and the decoded datapath controls
// assumes the serial control bus and forward-channel decoder run on CLK
`timescale 1ns/100ps

module dpc_datapath_config (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       FWD_LOAD,
  input  wire logic [6:0] FWD_DATA,
  input  wire logic       SER_PROT_CAPABLE,
  input  wire logic       PIX_VALID_PIN,
  output logic      [7:0] DATAPATH_CONTROL,
  output logic            PIX_FORWARD,
  output logic            PIX_VALID_ACTIVE,
  output logic            CONTENT_PROT_EN,
  output logic            PKT_AUDIO_EN,
  output logic            PKT_AUDIO_ON_PIXEL,
  output logic            QUAD_AUDIO_EN,
  output logic            COLOR_18BIT,
  output logic            AUDIO_INBAND
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic       pix_forward;
    logic       valid_active;
    logic       prot_en;
    logic       pkt_audio_en;
    logic       pkt_on_pixel;
    logic       quad_en;
    logic       color_18;
    logic       inband;
  } dpc_state_type;

  dpc_state_type state;
  dpc_state_type next_state;
  logic          valid_sync;
  logic          hit;
  logic          pass_eff;
  logic          strobe_act;

  dpc_sync2 u_valid_sync (
    .CLK      (CLK),
    .RST      (RST),
    .async_in (PIX_VALID_PIN),
    .sync_out (valid_sync)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    hit        = (REG_ADDR == dpc_pkg::DATAPATH_CONTROL_ADDR);
    // software write beats a forward load in the same cycle; it is the newer intent
    if (REG_WR && hit) begin
      next_state.cfg = REG_WDATA;
    end else if (FWD_LOAD && !state.cfg[dpc_pkg::FWD_LOAD_INHIBIT_BIT]) begin
      next_state.cfg[dpc_pkg::FWD_FIELD_WIDTH-1:0] = FWD_DATA;
    end
    if (REG_RD) begin
      next_state.rdata = hit ? state.cfg : dpc_pkg::UNMAPPED_READ_VALUE;
    end
    // decoded controls follow the stored value, one cycle behind it
    pass_eff   = state.cfg[dpc_pkg::PIXEL_PASS_UNGATED_BIT] & SER_PROT_CAPABLE;
    strobe_act = valid_sync ^ state.cfg[dpc_pkg::VALID_STROBE_POLARITY_BIT];
    next_state.valid_active = strobe_act;
    next_state.pix_forward  = pass_eff | strobe_act;
    next_state.prot_en      = !pass_eff;
    next_state.pkt_audio_en = !pass_eff;
    next_state.pkt_on_pixel = !pass_eff && !state.cfg[dpc_pkg::AUDIO_REPEATER_REGEN_BIT];
    next_state.quad_en      = state.cfg[dpc_pkg::QUAD_OVERRIDE_BIT] &
                              state.cfg[dpc_pkg::QUAD_ENABLE_BIT];
    next_state.color_18     = state.cfg[dpc_pkg::COLOR_18BIT_BIT];
    next_state.inband       = state.cfg[dpc_pkg::AUDIO_INBAND_BIT];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= '{cfg: dpc_pkg::DATAPATH_CONTROL_RESET, rdata: dpc_pkg::UNMAPPED_READ_VALUE,
                 prot_en: dpc_pkg::ALLOW_RESET_LEVEL, pkt_audio_en: dpc_pkg::ALLOW_RESET_LEVEL,
                 pkt_on_pixel: dpc_pkg::ALLOW_RESET_LEVEL, default: dpc_pkg::FLAG_RESET_LEVEL};
    end else begin
      state <= next_state;
    end
  end

  assign REG_RDATA          = state.rdata;
  assign DATAPATH_CONTROL   = state.cfg;
  assign PIX_FORWARD        = state.pix_forward;
  assign PIX_VALID_ACTIVE   = state.valid_active;
  assign CONTENT_PROT_EN    = state.prot_en;
  assign PKT_AUDIO_EN       = state.pkt_audio_en;
  assign PKT_AUDIO_ON_PIXEL = state.pkt_on_pixel;
  assign QUAD_AUDIO_EN      = state.quad_en;
  assign COLOR_18BIT        = state.color_18;
  assign AUDIO_INBAND       = state.inband;

  // ****************************************
  // checks
  // ****************************************
  AST_INHIBIT_HOLDS: assert property (@(posedge CLK) disable iff (RST)
    (FWD_LOAD && !(REG_WR && hit) && state.cfg[7]) |=> $stable(state.cfg))
    else $error("forward load changed register while inhibited");

  AST_FWD_LOADS: assert property (@(posedge CLK) disable iff (RST)
    (FWD_LOAD && !(REG_WR && hit) && !state.cfg[7]) |=> (state.cfg[6:0] == $past(FWD_DATA)))
    else $error("forward load not applied");

  AST_FWD_KEEPS_TOP: assert property (@(posedge CLK) disable iff (RST)
    (FWD_LOAD && !(REG_WR && hit)) |=> (state.cfg[7] == $past(state.cfg[7])))
    else $error("forward load touched bit 7");

  AST_LOCAL_WRITE: assert property (@(posedge CLK) disable iff (RST)
    (REG_WR && hit) |=> (DATAPATH_CONTROL == $past(REG_WDATA)))
    else $error("local write not applied at once");

  AST_PASS_FORWARDS: assert property (@(posedge CLK) disable iff (RST)
    (state.cfg[6] && SER_PROT_CAPABLE) |=> PIX_FORWARD)
    else $error("ungated pass did not forward pixels");

  AST_PASS_BLOCKS: assert property (@(posedge CLK) disable iff (RST)
    (state.cfg[6] && SER_PROT_CAPABLE) |=> (!CONTENT_PROT_EN && !PKT_AUDIO_EN))
    else $error("protection or audio left on during ungated pass");

  AST_PASS_NO_EFFECT: assert property (@(posedge CLK) disable iff (RST)
    !SER_PROT_CAPABLE |=> (CONTENT_PROT_EN && PKT_AUDIO_EN && PIX_FORWARD == PIX_VALID_ACTIVE))
    else $error("ungated pass acted without protection support");

  AST_POLARITY: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> (PIX_VALID_ACTIVE == ($past(valid_sync) ^ $past(state.cfg[5]))))
    else $error("strobe polarity wrong");

  AST_REGEN: assert property (@(posedge CLK) disable iff (RST)
    state.cfg[4] |=> !PKT_AUDIO_ON_PIXEL)
    else $error("audio on pixel pins despite regeneration");

  AST_QUAD: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> (QUAD_AUDIO_EN == ($past(state.cfg[3]) && $past(state.cfg[0]))))
    else $error("quad audio enable wrong");

  AST_COLOR: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> (COLOR_18BIT == $past(state.cfg[2])))
    else $error("colour depth select wrong");

  AST_INBAND: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> (AUDIO_INBAND == $past(state.cfg[1])))
    else $error("audio transport select wrong");

  // ****************************************
  // checks: register access
  // ****************************************
  AST_RD_MAPPED: assert property (@(posedge CLK) disable iff (RST)
    (REG_RD && hit) |=> (REG_RDATA == $past(state.cfg)))
    else $error("mapped read returned wrong value");

  AST_RD_UNMAPPED: assert property (@(posedge CLK) disable iff (RST)
    (REG_RD && !hit) |=> (REG_RDATA == dpc_pkg::UNMAPPED_READ_VALUE))
    else $error("unmapped read returned a value");

  AST_RD_HOLDS: assert property (@(posedge CLK) disable iff (RST)
    !REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  AST_CFG_HOLDS: assert property (@(posedge CLK) disable iff (RST)
    (!FWD_LOAD && !(REG_WR && hit)) |=> $stable(DATAPATH_CONTROL))
    else $error("register changed without write or load");

  AST_WRITE_WINS: assert property (@(posedge CLK) disable iff (RST)
    (REG_WR && hit && FWD_LOAD) |=> (DATAPATH_CONTROL == $past(REG_WDATA)))
    else $error("forward load beat a local write");

  // ****************************************
  // checks: decoded controls
  // ****************************************
  AST_PASS_OFF_FOLLOWS: assert property (@(posedge CLK) disable iff (RST)
    !(state.cfg[6] && SER_PROT_CAPABLE) |=> (PIX_FORWARD == PIX_VALID_ACTIVE))
    else $error("pixels forwarded apart from the strobe");

  AST_STROBE_FRAMES: assert property (@(posedge CLK) disable iff (RST)
    (!state.cfg[6] && !(valid_sync ^ state.cfg[5])) |=> !PIX_FORWARD)
    else $error("pixels forwarded while strobe idle");

  AST_PROT_NORMAL: assert property (@(posedge CLK) disable iff (RST)
    !(state.cfg[6] && SER_PROT_CAPABLE) |=> (CONTENT_PROT_EN && PKT_AUDIO_EN))
    else $error("protection or audio blocked without ungated pass");

  AST_PASS_NO_PIXEL_AUDIO: assert property (@(posedge CLK) disable iff (RST)
    (state.cfg[6] && SER_PROT_CAPABLE) |=> !PKT_AUDIO_ON_PIXEL)
    else $error("audio on pixel pins during ungated pass");

  AST_AUDIO_ON_PIXEL: assert property (@(posedge CLK) disable iff (RST)
    (!state.cfg[4] && !(state.cfg[6] && SER_PROT_CAPABLE)) |=> PKT_AUDIO_ON_PIXEL)
    else $error("audio missing from pixel pins");

  AST_QUAD_OFF: assert property (@(posedge CLK) disable iff (RST)
    !state.cfg[3] |=> !QUAD_AUDIO_EN)
    else $error("quad audio on without override");

endmodule // dpc_datapath_config

// ===== sim/dpc_ser_model.sv
// behavioural remote serializer: sends forward-channel loads on demand
// assumes the caller sits at a falling edge of CLK or between edges
`timescale 1ns/100ps

module dpc_ser_model (
  input  wire logic       CLK,
  output logic            FWD_LOAD,
  output logic      [6:0] FWD_DATA
);
  initial begin
    FWD_LOAD = 1'b0;
    FWD_DATA = 7'h2a;
  end

  // ****************************************
  // one load, a single-cycle pulse
  // ****************************************
  // data is inverted once the pulse ends so a stale value cannot pass for a load
  task automatic send(input logic [6:0] d);
    @(negedge CLK);
    FWD_LOAD = 1'b1;
    FWD_DATA = d;
    @(negedge CLK);
    FWD_LOAD = 1'b0;
    FWD_DATA = ~d;
  endtask
endmodule // dpc_ser_model

// ===== sim/tb.sv
// self-checking bench for the datapath configuration register
// assumes inputs change at the falling edge; decoded outputs lag the register
`timescale 1ns/100ps

module tb;
  logic       CLK, RST, REG_WR, REG_RD, SER_PROT_CAPABLE, PIX_VALID_PIN, FWD_LOAD;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, DATAPATH_CONTROL;
  logic [6:0] FWD_DATA;
  logic       PIX_FORWARD, PIX_VALID_ACTIVE, CONTENT_PROT_EN, PKT_AUDIO_EN;
  logic       PKT_AUDIO_ON_PIXEL, QUAD_AUDIO_EN, COLOR_18BIT, AUDIO_INBAND;
  int         errors, num_checks;
  logic [7:0] dec_out;
  logic [9:0] tbl [7] = '{10'h240, 10'h040, 10'h320, 10'h220, 10'h319, 10'h207, 10'h300};

  assign dec_out = {QUAD_AUDIO_EN, COLOR_18BIT, AUDIO_INBAND, PKT_AUDIO_ON_PIXEL,
                    CONTENT_PROT_EN, PKT_AUDIO_EN, PIX_VALID_ACTIVE, PIX_FORWARD};

  dpc_datapath_config dut (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FWD_LOAD(FWD_LOAD),
    .FWD_DATA(FWD_DATA), .SER_PROT_CAPABLE(SER_PROT_CAPABLE), .PIX_VALID_PIN(PIX_VALID_PIN),
    .DATAPATH_CONTROL(DATAPATH_CONTROL), .PIX_FORWARD(PIX_FORWARD),
    .PIX_VALID_ACTIVE(PIX_VALID_ACTIVE), .CONTENT_PROT_EN(CONTENT_PROT_EN),
    .PKT_AUDIO_EN(PKT_AUDIO_EN), .PKT_AUDIO_ON_PIXEL(PKT_AUDIO_ON_PIXEL),
    .QUAD_AUDIO_EN(QUAD_AUDIO_EN), .COLOR_18BIT(COLOR_18BIT), .AUDIO_INBAND(AUDIO_INBAND));

  dpc_ser_model ser (.CLK(CLK), .FWD_LOAD(FWD_LOAD), .FWD_DATA(FWD_DATA));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // two extra cycles let the decoded outputs follow the register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_ADDR = a; REG_WDATA = d; REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
    repeat (2) @(negedge CLK);
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge CLK);
    REG_ADDR = a; REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    @(negedge CLK);
  endtask

  function automatic logic [7:0] dec_exp(input logic [7:0] v, input logic c, input logic p);
    logic e, a;
    e = v[6] & c;
    a = p ^ v[5];
    return {v[3] & v[0], v[2], v[1], ~e & ~v[4], ~e, ~e, a, e | a};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(DATAPATH_CONTROL, 8'h00);
    chk(REG_RDATA, 8'h00);
    chk(dec_out, dec_exp(8'h00, 1'b1, 1'b0));
  endtask

  task automatic t_regs;
    wr(8'h22, 8'ha5);
    rd(8'h22);
    chk(REG_RDATA, 8'ha5);
    wr(8'h23, 8'hff);
    chk(DATAPATH_CONTROL, 8'ha5);
    rd(8'h23);
    chk(REG_RDATA, 8'h00);
  endtask

  task automatic t_fwd;
    wr(8'h22, 8'h00);
    ser.send(7'h55);
    chk(DATAPATH_CONTROL, 8'h55);
    wr(8'h22, 8'h8a);
    ser.send(7'h7f);
    chk(DATAPATH_CONTROL, 8'h8a);
    // inhibit clear, so the load is live and only priority can refuse it
    wr(8'h22, 8'h00);
    fork
      wr(8'h22, 8'h3c);
      ser.send(7'h41);
    join
    chk(DATAPATH_CONTROL, 8'h3c);
  endtask

  task automatic t_dec;
    foreach (tbl[i]) begin
      SER_PROT_CAPABLE = tbl[i][9];
      PIX_VALID_PIN = tbl[i][8];
      wr(8'h22, tbl[i][7:0]);
      repeat (4) @(negedge CLK);
      chk(dec_out, dec_exp(tbl[i][7:0], tbl[i][9], tbl[i][8]));
    end
  endtask

  task automatic t_rst;
    wr(8'h22, 8'hff);
    rd(8'h22);
    chk(REG_RDATA, 8'hff);
    RST = 1'b1;
    repeat (3) @(negedge CLK);
    RST = 1'b0;
    t_reset;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  initial begin
    repeat (3000) @(posedge CLK);
    errors++;
    report_and_stop;
  end

  initial begin
    RST = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 8'h00; REG_WDATA = 8'h00;
    SER_PROT_CAPABLE = 1'b1; PIX_VALID_PIN = 1'b0;
    repeat (6) @(negedge CLK);
    RST = 1'b0;
    t_reset;
    t_regs;
    t_fwd;
    t_dec;
    t_rst;
    report_and_stop;
  end
endmodule // tb
